// ### dv/regv_bank_monitor.sv
// Purpose: Bus and output checks of the regulator bank
// Assumes: Sees only the top module ports
// Notes:   Bound to every regv_bank instance
`include "regv_defs.svh"

module regv_bank_monitor
    import regv_pkg::*;
(
    input  wire logic                       MCLK_I,
    input  wire logic                       RST_I,
    input  wire logic                       CYC_I,
    input  wire logic                       STB_I,
    input  wire logic                       WE_I,
    input  wire logic [31:0]                ADR_I,
    input  wire logic [31:0]                DAT_O,
    input  wire logic                       ACK_O,
    input  wire logic                       GLOBAL_POWER_ENABLE_PIN_I,
    input  wire logic [`REGV_DED_COUNT-1:0] DEDICATED_ENABLE_PIN_I,
    input  wire logic [`REGV_COUNT-1:0]     REG_ON_O,
    input  wire logic [`REGV_COUNT-1:0]     REG_LOWPWR_O,
    input  wire logic [`REGV_COUNT*6-1:0]   OUTPUT_VOLTAGE_CODE_O,
    input  wire logic [`REGV_COUNT*12-1:0]  TARGET_MV_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    // ****************************************************************
    // Bus handshake and read data
    // ****************************************************************
    a_ack_single_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not answered next cycle");
    a_ack_needs_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_idle_data_zero: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_cause_top_zero: assert property (
        ACK_O && $past(ADR_I) == 32'h0000_0380 && !$past(WE_I) |-> DAT_O[31:7] == 25'h000_0000)
        else $error("cause register top bit not zero");

    // ****************************************************************
    // Regulator outputs
    // ****************************************************************
    a_lowpwr_needs_on: assert property ((REG_LOWPWR_O & ~REG_ON_O) == 22'h00_0000)
        else $error("low power flagged on an off output");
    a_outputs_hold_quiet: assert property (
        !$past(RST_I) && !ACK_O && $stable(GLOBAL_POWER_ENABLE_PIN_I)
        && $stable(DEDICATED_ENABLE_PIN_I) |=> $stable(REG_ON_O) && $stable(REG_LOWPWR_O))
        else $error("outputs moved with pins and registers quiet");
    for (genvar i = 0; i < `REGV_COUNT; i++) begin : g_mv
        a_mv_tracks_code: assert property (
            !$past(RST_I) |-> TARGET_MV_O[i*12+:12] ==
            12'h0320 + 12'h0032 * 12'($past(OUTPUT_VOLTAGE_CODE_O[i*6+:6])))
            else $error("target millivolts do not match code");
    end

    c_write_ack: cover property (ACK_O && $past(WE_I));
    c_lowpwr_seen: cover property (|REG_LOWPWR_O);
    c_cause_read: cover property (ACK_O && $past(ADR_I) == 32'h0000_0380);
endmodule

bind regv_bank regv_bank_monitor i_mon (.MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .GLOBAL_POWER_ENABLE_PIN_I(GLOBAL_POWER_ENABLE_PIN_I),
    .DEDICATED_ENABLE_PIN_I(DEDICATED_ENABLE_PIN_I), .REG_ON_O(REG_ON_O),
    .REG_LOWPWR_O(REG_LOWPWR_O), .OUTPUT_VOLTAGE_CODE_O(OUTPUT_VOLTAGE_CODE_O),
    .TARGET_MV_O(TARGET_MV_O));

// ### dv/regv_host_model.sv
// Purpose: Host processor side, classic Wishbone master
// Assumes: Slave answers at its own pace
// Notes:   Released address and data lines show the inverse of the last value
module regv_host_model
    import regv_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [31:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 32'h0000_0000;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    task automatic xfer(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                        input regv_byte_t wd, output regv_byte_t rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= {24'h00_0000, wd};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= ~adr;
        dat_o <= ~{24'h00_0000, wd};
    endtask
endmodule

// ### dv/tb_top.sv
// Purpose: Self-checking bench of the regulator enable control bank
// Assumes: Host model issues all register cycles
// Notes:   Expected outputs come from a mode table kept here
module tb_top
    import regv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] idx_tab [22] = '{8'h61, 8'h62, 8'h63, 8'h67, 8'h68, 8'h69, 8'h6a,
        8'h6b, 8'h6c, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77,
        8'h78, 8'h79, 8'h7a};
    localparam logic [7:0] rst_tab [22] = '{8'hd4, 8'hd4, 8'hd4, 8'h2c, 8'hd4, 8'hd4, 8'hec,
        8'hd4, 8'hd4, 8'hd4, 8'he8, 8'h28, 8'h2c, 8'h2c, 8'h2c, 8'h32, 8'h28, 8'h2c, 8'h08,
        8'h14, 8'h14, 8'h14};
    logic         clk, rst, cyc, stb, we, ack, gpin;
    logic [31:0]  adr, wdat, rdat;
    logic [3:0]   sel;
    logic [2:0]   dpin;
    logic [6:0]   cause;
    logic [21:0]  on_v, lp_v;
    logic [131:0] code_v;
    logic [263:0] mv_v;
    logic [1:0]   mode_q [22];
    logic [5:0]   code_q [22];
    int           err_count = 0, checked = 0, cycles = 0;

    regv_bank i_dut (.MCLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .GLOBAL_POWER_ENABLE_PIN_I(gpin), .DEDICATED_ENABLE_PIN_I(dpin),
        .POWER_ON_CAUSE_I(cause), .REG_ON_O(on_v), .REG_LOWPWR_O(lp_v),
        .OUTPUT_VOLTAGE_CODE_O(code_v), .TARGET_MV_O(mv_v));
    regv_host_model i_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************************************
    // Expected decode, returns {on, lowpwr}
    // ****************************************************************
    function automatic logic [1:0] exp_one(int i, logic [1:0] m, logic g, logic [2:0] d);
        logic p;
        p = (i == 1) ? d[0] : (i == 11) ? d[1] : (i == 16) ? d[2] : 1'b0;
        if (i == 1 || i == 11 || i == 16)
            case (m)
                2'h0: return {p, 1'b0};
                2'h1: return {g | p, 1'b0};
                2'h2: return {1'b1, ~(g | p)};
                default: return 2'h2;
            endcase
        case (m)
            2'h0: return {i == 0, 1'b0};
            2'h1: return {g, 1'b0};
            2'h2: return {1'b1, ~g};
            default: return 2'h2;
        endcase
    endfunction

    function automatic logic [31:0] adr_of(logic [7:0] ix);
        return {22'h00_0000, ix, 2'b00};
    endfunction

    task automatic chk_reg(input regv_byte_t got, input regv_byte_t exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [43:0] got, input logic [43:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t outputs %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ix, input regv_byte_t d, input logic [3:0] s = 4'h1);
        regv_byte_t r;
        i_host.xfer(1'b1, adr_of(ix), s, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input regv_byte_t e);
        regv_byte_t r;
        i_host.xfer(1'b0, a, 4'hf, 8'h00, r);
        chk_reg(r, e);
    endtask

    task automatic chk_outs();
        logic [21:0] eon, elp;
        logic [1:0]  e;
        #1;
        for (int i = 0; i < 22; i++) begin
            e = exp_one(i, mode_q[i], gpin, dpin);
            eon[i] = e[1];
            elp[i] = e[0];
            chk_out(44'({code_v[i*6+:6], mv_v[i*12+:12]}),
                44'({code_q[i], 12'h0320 + 12'h0032 * 12'(code_q[i])}));
        end
        chk_out({on_v, lp_v}, {eon, elp});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("ERROR %0t run did not finish", $time);
            complete_run();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        gpin = 1'b0;
        dpin = 3'h0;
        cause = 7'h5a;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        cause <= 7'h25;
        for (int i = 0; i < 22; i++) begin
            mode_q[i] = rst_tab[i][7:6];
            code_q[i] = rst_tab[i][5:0];
            rd_chk(adr_of(idx_tab[i]), rst_tab[i]);
        end
        chk_outs();
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 22; i++) begin
                mode_q[i] = 2'(m);
                code_q[i] = 6'(i * 3 + m * 17);
                wr(idx_tab[i], {mode_q[i], code_q[i]});
                rd_chk(adr_of(idx_tab[i]), {mode_q[i], code_q[i]});
            end
            for (int p = 0; p < 16; p++) begin
                @(posedge clk);
                gpin <= p[3];
                dpin <= 3'(p);
                repeat (2) @(posedge clk);
                chk_outs();
            end
        end
        wr(8'h64, 8'ha5);
        rd_chk(adr_of(8'h64), 8'h00);
        wr(8'he0, 8'hff);
        rd_chk(adr_of(8'he0), 8'h5a);
        wr(idx_tab[2], 8'h00, 4'he);
        rd_chk(adr_of(idx_tab[2]), {mode_q[2], code_q[2]});
        rd_chk(32'h0000_0185, 8'h00);
        complete_run();
    end
endmodule

// ### src/regv_bank.sv
// Purpose: Regulator enable control register bank with a classic Wishbone slave
// Assumes: Single clock MCLK_I, asynchronous active high reset RST_I
// Notes:   Register at index N sits at byte address 4*N, data in bits 7:0
//
// Functional notes
// [R1] A standard regulator in enable mode 00 is off whatever the global pin does.
// [R2] A standard regulator in mode 01 is on in normal mode while the global pin is high, else off.
// [R3] A standard regulator in mode 10 stays on, normal with the global pin high, low power when low.
// [R4] A standard regulator in mode 11 is on in normal mode regardless of the global pin.
// [R5] A dedicated-pin regulator in mode 00 follows only its own pin: low off, high normal.
// [R6] A dedicated-pin regulator in mode 01 is off only when both pins are low.
// [R7] A dedicated-pin regulator in mode 10 is on, low power when both pins are low.
// [R8] A dedicated-pin regulator in mode 11 is on in normal mode regardless of both pins.
// [R9] The always-on regulator never turns off in mode 00; other modes act as standard.
// [R10] Mode resets to 11 for regulators 3 and 4 and to 00 for regulators 18 and 23.
// [R11] Mode resets to 00 for 9, 19-22, 24-28 and to 11 for 5, 10-14, 16, 17.
// [R12] Output code maps to 0.80 V plus 50 mV per step, up to 3.95 V at code 0x3F.
// [R13] Each control register decodes at its own index, 0x61 for 3 up to 0x7A for 28.
// [R14] The power-on cause register is read only with bit 7 reading zero.
// [R15] Outputs follow pin levels and register writes with no further software action.
//
// The Wishbone interface to the registers is this design's own decision.
`include "regv_defs.svh"

module regv_bank
    import regv_pkg::*;
(
    input  wire logic                          MCLK_I,
    input  wire logic                          RST_I,
    input  wire logic                          CYC_I,
    input  wire logic                          STB_I,
    input  wire logic                          WE_I,
    input  wire logic [31:0]                   ADR_I,
    input  wire logic [3:0]                    SEL_I,
    input  wire logic [31:0]                   DAT_I,
    output logic      [31:0]                   DAT_O,
    output logic                               ACK_O,
    input  wire logic                          GLOBAL_POWER_ENABLE_PIN_I,
    input  wire logic [`REGV_DED_COUNT-1:0]    DEDICATED_ENABLE_PIN_I,
    input  wire logic [`REGV_CAUSE_W-1:0]      POWER_ON_CAUSE_I,
    output logic      [`REGV_COUNT-1:0]        REG_ON_O,
    output logic      [`REGV_COUNT-1:0]        REG_LOWPWR_O,
    output logic      [`REGV_COUNT*6-1:0]      OUTPUT_VOLTAGE_CODE_O,
    output logic      [`REGV_COUNT*12-1:0]     TARGET_MV_O
);

    // ****************************************************************
    // Register map tables
    // ****************************************************************
    localparam regv_byte_t [`REGV_COUNT-1:0] IDX_TABLE = {
        `REGV_IDX_REG28, `REGV_IDX_REG27, `REGV_IDX_REG26, `REGV_IDX_REG25,
        `REGV_IDX_REG24, `REGV_IDX_REG23, `REGV_IDX_REG22, `REGV_IDX_REG21,
        `REGV_IDX_REG20, `REGV_IDX_REG19, `REGV_IDX_REG18, `REGV_IDX_REG17,
        `REGV_IDX_REG16, `REGV_IDX_REG14, `REGV_IDX_REG13, `REGV_IDX_REG12,
        `REGV_IDX_REG11, `REGV_IDX_REG10, `REGV_IDX_REG9,  `REGV_IDX_REG5,
        `REGV_IDX_REG4,  `REGV_IDX_REG3
    };

    localparam regv_byte_t [`REGV_COUNT-1:0] RST_TABLE = {
        `REGV_RST_REG28, `REGV_RST_REG27, `REGV_RST_REG26, `REGV_RST_REG25,
        `REGV_RST_REG24, `REGV_RST_REG23, `REGV_RST_REG22, `REGV_RST_REG21,
        `REGV_RST_REG20, `REGV_RST_REG19, `REGV_RST_REG18, `REGV_RST_REG17,
        `REGV_RST_REG16, `REGV_RST_REG14, `REGV_RST_REG13, `REGV_RST_REG12,
        `REGV_RST_REG11, `REGV_RST_REG10, `REGV_RST_REG9,  `REGV_RST_REG5,
        `REGV_RST_REG4,  `REGV_RST_REG3
    };

    localparam logic [`REGV_COUNT-1:0] SPECIAL_MASK   = `REGV_SPECIAL_MASK;
    localparam logic [`REGV_COUNT-1:0] DEDICATED_MASK = `REGV_DEDICATED_MASK;

    // Constant reset image of the whole state
    function automatic regv_state_s reset_state();
        regv_state_s s;
        s = '0;
        s.ctrl = RST_TABLE; // [R10] [R11]
        return s;
    endfunction

    // Target voltage in millivolts for a six bit code
    function automatic regv_mv_t code_to_mv(input logic [`REGV_CODE_W-1:0] code);
        logic [17:0] prod;
        prod = 18'({12'h000, code}) * 18'(`REGV_MV_STEP);
        return regv_mv_t'(prod[11:0] + `REGV_MV_BASE);
    endfunction

    // ****************************************************************
    // State and next state
    // ****************************************************************
    regv_state_s state_reg;
    regv_state_s state_next;

    // ****************************************************************
    // Per regulator enable decode
    // ****************************************************************
    regv_out_s [`REGV_COUNT-1:0] dec;

    genvar gi;
    generate
        for (gi = 0; gi < `REGV_COUNT; gi++) begin : g_dec
            localparam regv_kind_e KIND =
                SPECIAL_MASK[gi]   ? REGV_KIND_SPECIAL :
                DEDICATED_MASK[gi] ? REGV_KIND_DEDICATED : REGV_KIND_STANDARD;
            localparam int DED_SEL =
                (gi == `REGV_DED_POS_A) ? 0 :
                (gi == `REGV_DED_POS_B) ? 1 :
                (gi == `REGV_DED_POS_C) ? 2 : 0;
            logic ded_pin;
            assign ded_pin = DEDICATED_MASK[gi] ? DEDICATED_ENABLE_PIN_I[DED_SEL] : 1'b0;

            regv_mode_decode #(
                .KIND (KIND)
            ) u_dec (
                .mode_i          (state_reg.ctrl[gi][`REGV_MODE_HI:`REGV_MODE_LO]),
                .global_pin_i    (GLOBAL_POWER_ENABLE_PIN_I),
                .dedicated_pin_i (ded_pin),
                .out_o           (dec[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Bus address decode
    // ****************************************************************
    logic                    bus_req;
    logic                    idx_ok;
    regv_byte_t              bus_idx;
    logic [`REGV_COUNT-1:0]  hit;
    logic                    cause_hit;

    assign bus_req   = CYC_I & STB_I & ~state_reg.ack;
    assign idx_ok    = (ADR_I[31:10] == 22'h00_0000) & (ADR_I[1:0] == 2'b00);
    assign bus_idx   = ADR_I[9:2];
    assign cause_hit = idx_ok & (bus_idx == `REGV_IDX_CAUSE);

    always_comb begin
        for (int i = 0; i < `REGV_COUNT; i++) begin
            hit[i] = idx_ok & (bus_idx == IDX_TABLE[i]); // [R13]
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;

        // Single cycle answer, dropped the cycle after
        state_next.ack  = bus_req;
        state_next.rdat = 8'h00;

        if (bus_req && WE_I && SEL_I[0]) begin
            for (int i = 0; i < `REGV_COUNT; i++) begin
                if (hit[i]) begin
                    state_next.ctrl[i] = DAT_I[7:0]; // [R15]
                end
            end
        end

        if (bus_req && !WE_I) begin
            for (int i = 0; i < `REGV_COUNT; i++) begin
                if (hit[i]) begin
                    state_next.rdat = state_reg.ctrl[i];
                end
            end
            if (cause_hit) begin
                state_next.rdat = {1'b0, state_reg.cause}; // [R14]
            end
        end

        // Cause is caught once after reset release, never written by the bus
        if (!state_reg.cause_held) begin
            state_next.cause      = POWER_ON_CAUSE_I; // [R14]
            state_next.cause_held = 1'b1;
        end

        for (int i = 0; i < `REGV_COUNT; i++) begin
            state_next.on[i]     = dec[i].on; // [R15]
            state_next.lowpwr[i] = dec[i].on & dec[i].lowpwr;
            state_next.mv[i]     =
                code_to_mv(state_reg.ctrl[i][`REGV_CODE_HI:`REGV_CODE_LO]); // [R12]
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= reset_state();
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign ACK_O        = state_reg.ack;
    assign DAT_O        = {24'h00_0000, state_reg.rdat};
    assign REG_ON_O     = state_reg.on;
    assign REG_LOWPWR_O = state_reg.lowpwr;

    generate
        for (gi = 0; gi < `REGV_COUNT; gi++) begin : g_out
            assign OUTPUT_VOLTAGE_CODE_O[gi*6 +: 6] =
                state_reg.ctrl[gi][`REGV_CODE_HI:`REGV_CODE_LO];
            assign TARGET_MV_O[gi*12 +: 12] = state_reg.mv[gi];
        end
    endgenerate

endmodule

// ### src/regv_defs.svh
// Purpose: Constants of the regulator enable control bank
// Assumes: Included by the package, the regv_bank module and the bank monitor
// Notes:   Register offsets are word indexes; the byte address is four times the index
`ifndef REGV_DEFS_SVH
`define REGV_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define REGV_COUNT          22
`define REGV_DED_COUNT      3
`define REGV_CODE_W         6
`define REGV_MV_W           12

// ****************************************************************
// Register indexes
// ****************************************************************
`define REGV_IDX_REG3       8'h61
`define REGV_IDX_REG4       8'h62
`define REGV_IDX_REG5       8'h63
`define REGV_IDX_REG9       8'h67
`define REGV_IDX_REG10      8'h68
`define REGV_IDX_REG11      8'h69
`define REGV_IDX_REG12      8'h6a
`define REGV_IDX_REG13      8'h6b
`define REGV_IDX_REG14      8'h6c
`define REGV_IDX_REG16      8'h6e
`define REGV_IDX_REG17      8'h6f
`define REGV_IDX_REG18      8'h70
`define REGV_IDX_REG19      8'h71
`define REGV_IDX_REG20      8'h72
`define REGV_IDX_REG21      8'h73
`define REGV_IDX_REG22      8'h74
`define REGV_IDX_REG23      8'h75
`define REGV_IDX_REG24      8'h76
`define REGV_IDX_REG25      8'h77
`define REGV_IDX_REG26      8'h78
`define REGV_IDX_REG27      8'h79
`define REGV_IDX_REG28      8'h7a
`define REGV_IDX_CAUSE      8'he0

// ****************************************************************
// Reset values
// ****************************************************************
`define REGV_RST_REG3       8'hd4
`define REGV_RST_REG4       8'hd4
`define REGV_RST_REG5       8'hd4
`define REGV_RST_REG9       8'h2c
`define REGV_RST_REG10      8'hd4
`define REGV_RST_REG11      8'hd4
`define REGV_RST_REG12      8'hec
`define REGV_RST_REG13      8'hd4
`define REGV_RST_REG14      8'hd4
`define REGV_RST_REG16      8'hd4
`define REGV_RST_REG17      8'he8
`define REGV_RST_REG18      8'h28
`define REGV_RST_REG19      8'h2c
`define REGV_RST_REG20      8'h2c
`define REGV_RST_REG21      8'h2c
`define REGV_RST_REG22      8'h32
`define REGV_RST_REG23      8'h28
`define REGV_RST_REG24      8'h2c
`define REGV_RST_REG25      8'h08
`define REGV_RST_REG26      8'h14
`define REGV_RST_REG27      8'h14
`define REGV_RST_REG28      8'h14

// ****************************************************************
// Fields and regulator kinds
// ****************************************************************
`define REGV_MODE_HI        7
`define REGV_MODE_LO        6
`define REGV_CODE_HI        5
`define REGV_CODE_LO        0
`define REGV_CAUSE_W        7
`define REGV_SPECIAL_MASK   22'h00_0001
`define REGV_DEDICATED_MASK 22'h1_0802
`define REGV_DED_POS_A      1
`define REGV_DED_POS_B      11
`define REGV_DED_POS_C      16
`define REGV_MV_BASE        12'h0320
`define REGV_MV_STEP        12'h0032

`endif

// ### src/regv_mode_decode.sv
// Purpose: Enable mode decode of one regulator
// Assumes: Pin levels are synchronous to the clock
// Notes:   Purely combinational; the caller registers the result
module regv_mode_decode
    import regv_pkg::*;
#(
    parameter regv_kind_e KIND = REGV_KIND_STANDARD
) (
    input  wire logic [1:0] mode_i,
    input  wire logic       global_pin_i,
    input  wire logic       dedicated_pin_i,
    output regv_out_s       out_o
);

    always_comb begin
        out_o = '0;
        case (regv_mode_e'(mode_i))
            REGV_EN_OFF_OR_PIN: begin
                if (KIND == REGV_KIND_DEDICATED) begin
                    out_o.on = dedicated_pin_i; // [R5]
                end else if (KIND == REGV_KIND_SPECIAL) begin
                    out_o.on = 1'b1; // [R9]
                end else begin
                    out_o.on = 1'b0; // [R1]
                end
            end
            REGV_EN_GLOBAL: begin
                if (KIND == REGV_KIND_DEDICATED) begin
                    out_o.on = global_pin_i | dedicated_pin_i; // [R6]
                end else begin
                    out_o.on = global_pin_i; // [R2]
                end
            end
            REGV_EN_LOWPOWER: begin
                out_o.on = 1'b1;
                if (KIND == REGV_KIND_DEDICATED) begin
                    out_o.lowpwr = ~global_pin_i & ~dedicated_pin_i; // [R7]
                end else begin
                    out_o.lowpwr = ~global_pin_i; // [R3]
                end
            end
            REGV_EN_ALWAYS: begin
                out_o.on = 1'b1; // [R4] [R8]
            end
            default: begin
                out_o = '0;
            end
        endcase
    end

endmodule

// ### src/regv_pkg.sv
// Purpose: Types of the regulator enable control bank
// Assumes: regv_defs.svh holds all numbers
// Notes:   State of the top module is one packed struct
`include "regv_defs.svh"

package regv_pkg;

    typedef enum logic [1:0] {
        REGV_EN_OFF_OR_PIN = 2'b00,
        REGV_EN_GLOBAL     = 2'b01,
        REGV_EN_LOWPOWER   = 2'b10,
        REGV_EN_ALWAYS     = 2'b11
    } regv_mode_e;

    typedef enum logic [1:0] {
        REGV_KIND_STANDARD  = 2'b00,
        REGV_KIND_DEDICATED = 2'b01,
        REGV_KIND_SPECIAL   = 2'b10
    } regv_kind_e;

    typedef logic [7:0]                 regv_byte_t;
    typedef logic [`REGV_MV_W-1:0]      regv_mv_t;

    typedef struct packed {
        regv_byte_t [`REGV_COUNT-1:0]   ctrl;
        logic                           ack;
        regv_byte_t                     rdat;
        logic [`REGV_COUNT-1:0]         on;
        logic [`REGV_COUNT-1:0]         lowpwr;
        regv_mv_t [`REGV_COUNT-1:0]     mv;
        logic [`REGV_CAUSE_W-1:0]       cause;
        logic                           cause_held;
    } regv_state_s;

    typedef struct packed {
        logic on;
        logic lowpwr;
    } regv_out_s;

endpackage
